/* common/cycle_timer_if.sv */
// Load and status signals between the timing block and one cycle timer.
`timescale 1ns/1ps
`default_nettype none
interface cycle_timer_if;
  logic       load;   // Load the counter this cycle.
  logic [7:0] value;  // Cycles to count.
  logic       busy;   // Counter is not yet zero.
  logic       last;   // Counter holds one, so it ends at the next edge.

  modport ctl (output load, output value, input busy, input last);
  modport tmr (input load, input value, output busy, output last);
endinterface : cycle_timer_if
`default_nettype wire

/* common/sdram_timing_pkg.sv */
// Timing constants, command codes and power states for the SDRAM cycle timing block.
package sdram_timing_pkg;
  // Average clock period of the input clock, in picoseconds.
  localparam int TCK_PS = 20000;
  // Nanosecond parameters, in picoseconds.
  localparam int TRCD_PS = 13125;
  localparam int TRP_PS  = 13125;
  localparam int TRFC_PS = 160000;
  // Cycle counts, rounded up to whole clock cycles.
  localparam logic [7:0] TRCD_NCK = 8'((TRCD_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [7:0] TRP_NCK  = 8'((TRP_PS + TCK_PS - 1) / TCK_PS);
  localparam logic [7:0] TRFC_NCK = 8'((TRFC_PS + TCK_PS - 1) / TCK_PS);
  // Short calibration window, in clock cycles.
  localparam logic [7:0] ZQCS_NCK = 8'h40;
  // Internal write start offset after write latency.
  localparam logic [7:0] WR_START_BL8 = 8'h04;
  localparam logic [7:0] WR_START_BC4 = 8'h02;
  // Impedance code step applied by one short calibration.
  localparam logic [5:0] ZQ_STEP     = 6'h01;
  localparam logic [5:0] ZQ_CODE_RST = 6'h20;

  // Command codes as decoded from the command pins.
  typedef enum logic [2:0] {
    CMD_NOP  = 3'h0,
    CMD_ACT  = 3'h1,
    CMD_PRE  = 3'h2,
    CMD_REF  = 3'h3,
    CMD_WR   = 3'h4,
    CMD_WRA  = 3'h5,
    CMD_MRS  = 3'h6,
    CMD_ZQCS = 3'h7
  } cmd_t;

  // Power state of the device.
  typedef enum logic [2:0] {
    PWR_ACTIVE  = 3'b001,
    PWR_PENDING = 3'b010,
    PWR_DOWN    = 3'b100
  } pwr_t;
endpackage : sdram_timing_pkg

/* src/cycle_timer.sv */
// Down counter that measures a delay in whole clock edges.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
  // Clock and reset.
  input wire logic   clock_i,
  input wire logic   rst_i,
  // Control from the owner.
  cycle_timer_if.tmr t
);
  logic [7:0] cnt;  // Remaining cycles.

  // A load restarts the count; otherwise it falls by one per edge to zero.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= 8'h00;
    else if (t.load)
      cnt <= t.value;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  assign t.busy = (cnt != 8'h00);
  assign t.last = (cnt == 8'h01);
endmodule : cycle_timer
`default_nettype wire

/* src/sdram_cycle_timing.sv */
// Device-side command spacing, write start, power-down entry and short calibration.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Device honours rounded-up nanosecond cycle counts.
// - Write starts WL+4, or WL+2 fixed chop.
// - Power-down applies after pending operations finish.
// - Write recovery is the programmed cycle value.
// - Short calibration corrects within 64 cycles; here one command moves the code one ZQ_STEP toward the reference.
module sdram_cycle_timing (
  // Clock and reset.
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // Command pins, decoded.
  input  wire logic                 cke_i,
  input  wire sdram_timing_pkg::cmd_t cmd_i,
  // Mode register settings.
  input  wire logic [3:0]           wl_i,
  input  wire logic [4:0]           wr_cycles_i,
  input  wire logic                 bc4_fixed_i,
  // Calibration reference.
  input  wire logic [5:0]           zq_target_i,
  // Status.
  output logic                      row_busy_o,
  output logic                      wr_start_o,
  output logic                      wr_prech_o,
  output logic                      power_down_o,
  output logic                      zq_busy_o,
  output logic                      zq_done_o,
  output logic [5:0]                zq_code_o,
  output logic                      timing_error_o
);
  // Spacing from a precharge to the next accepted row command.
  localparam int PRE_D = int'(sdram_timing_pkg::TRP_NCK);
  // Calibration window length.
  localparam int ZQ_D  = int'(sdram_timing_pkg::ZQCS_NCK);

  cycle_timer_if row_t ();   // Activation, precharge and refresh in progress.
  cycle_timer_if wst_t ();   // Delay from write command to internal write start.
  cycle_timer_if wrec_t ();  // Write recovery before auto-precharge.
  cycle_timer_if zq_t ();    // Short calibration window.

  cycle_timer u_row  (.clock_i(clock_i), .rst_i(rst_i), .t(row_t));
  cycle_timer u_wst  (.clock_i(clock_i), .rst_i(rst_i), .t(wst_t));
  cycle_timer u_wrec (.clock_i(clock_i), .rst_i(rst_i), .t(wrec_t));
  cycle_timer u_zq   (.clock_i(clock_i), .rst_i(rst_i), .t(zq_t));

  sdram_timing_pkg::pwr_t pwr;       // Power state.
  sdram_timing_pkg::pwr_t next_pwr;  // Power state for the next edge.
  logic active;                      // Commands are taken only in the active state.
  logic row_cmd;                     // Command that occupies the row machinery.
  logic wr_cmd;                      // Write with or without auto-precharge.
  logic ap_pend;                     // Auto-precharge waits for write recovery.
  logic any_busy;                    // Some operation is still running.
  logic row_free;                    // Row timer is idle or ends at this edge.

  assign active  = (pwr == sdram_timing_pkg::PWR_ACTIVE) && cke_i;
  assign row_cmd = active && ((cmd_i == sdram_timing_pkg::CMD_ACT) ||
                              (cmd_i == sdram_timing_pkg::CMD_PRE) ||
                              (cmd_i == sdram_timing_pkg::CMD_REF));
  assign wr_cmd  = active && ((cmd_i == sdram_timing_pkg::CMD_WR) ||
                              (cmd_i == sdram_timing_pkg::CMD_WRA));
  assign any_busy = row_t.busy || wst_t.busy || wrec_t.busy || zq_t.busy || ap_pend;
  // A count of N loaded at edge T still reads one at edge T+N. That last cycle
  // must already take the next command, or a rounded-up spacing is refused.
  assign row_free = !row_t.busy || row_t.last;

  // Row timer. The recovery-driven precharge wins over a command in the same
  // cycle; that command is dropped, and is flagged below only if the row timer still runs.
  always_comb
  begin
    row_t.load  = 1'b0;
    row_t.value = 8'h00;
    if (wrec_t.last && ap_pend)
    begin
      row_t.load  = 1'b1;
      row_t.value = sdram_timing_pkg::TRP_NCK;
    end
    else if (row_cmd && row_free)
    begin
      row_t.load = 1'b1;
      unique case (cmd_i)
        sdram_timing_pkg::CMD_ACT: row_t.value = sdram_timing_pkg::TRCD_NCK;
        sdram_timing_pkg::CMD_PRE: row_t.value = sdram_timing_pkg::TRP_NCK;
        default:                   row_t.value = sdram_timing_pkg::TRFC_NCK;
      endcase
    end
  end

  // Write start delay: write latency plus the burst-dependent offset. A second
  // write before the first has started restarts the delay; the controller
  // model spaces writes one edge apart, so only the bench's waits prevent that.
  always_comb
  begin
    wst_t.load  = wr_cmd;
    wst_t.value = {4'h0, wl_i} + (bc4_fixed_i ? sdram_timing_pkg::WR_START_BC4
                                              : sdram_timing_pkg::WR_START_BL8);
  end

  // Write recovery is counted from the internal write start in the cycles
  // programmed in the mode register, not from any nanosecond figure.
  always_comb
  begin
    wrec_t.load  = wst_t.last;
    wrec_t.value = {3'h0, wr_cycles_i};
  end

  // Calibration window opens on a short calibration command when idle.
  always_comb
  begin
    zq_t.load  = active && (cmd_i == sdram_timing_pkg::CMD_ZQCS) && !zq_t.busy;
    zq_t.value = sdram_timing_pkg::ZQCS_NCK;
  end

  // Auto-precharge request: set by a write with precharge, cleared when the
  // recovery ends and the precharge is launched.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ap_pend <= 1'b0;
    else if (wr_cmd && (cmd_i == sdram_timing_pkg::CMD_WRA))
      ap_pend <= 1'b1;
    else if (wrec_t.last)
      ap_pend <= 1'b0;
  end

  // Power state. Clock-enable low is accepted at any time, but the low-power
  // state only takes effect once every running operation has finished.
  always_comb
  begin
    next_pwr = pwr;
    unique case (pwr)
      sdram_timing_pkg::PWR_ACTIVE:
      begin
        if (!cke_i)
          next_pwr = any_busy ? sdram_timing_pkg::PWR_PENDING
                              : sdram_timing_pkg::PWR_DOWN;
      end
      sdram_timing_pkg::PWR_PENDING:
      begin
        if (cke_i)
          next_pwr = sdram_timing_pkg::PWR_ACTIVE;
        else if (!any_busy)
          next_pwr = sdram_timing_pkg::PWR_DOWN;
      end
      sdram_timing_pkg::PWR_DOWN:
      begin
        if (cke_i)
          next_pwr = sdram_timing_pkg::PWR_ACTIVE;
      end
      default: next_pwr = sdram_timing_pkg::PWR_ACTIVE;
    endcase
  end

  // Power state register.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pwr <= sdram_timing_pkg::PWR_ACTIVE;
    else
      pwr <= next_pwr;
  end

  // Registered status outputs; each lags its internal source by one edge.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      row_busy_o   <= 1'b0;
      wr_start_o   <= 1'b0;
      wr_prech_o   <= 1'b0;
      power_down_o <= 1'b0;
      zq_busy_o    <= 1'b0;
    end
    else
    begin
      row_busy_o   <= row_t.busy;
      wr_start_o   <= wst_t.last;
      wr_prech_o   <= wrec_t.last && ap_pend;
      power_down_o <= (next_pwr == sdram_timing_pkg::PWR_DOWN);
      zq_busy_o    <= zq_t.busy;
    end
  end

  // Calibration: one step of the impedance code toward the reference per
  // command. The step size bounds how far drift may run between commands.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      zq_code_o <= sdram_timing_pkg::ZQ_CODE_RST;
      zq_done_o <= 1'b0;
    end
    else
    begin
      zq_done_o <= zq_t.last;
      if (zq_t.last && (zq_code_o < zq_target_i))
        zq_code_o <= zq_code_o + sdram_timing_pkg::ZQ_STEP;
      else if (zq_t.last && (zq_code_o > zq_target_i))
        zq_code_o <= zq_code_o - sdram_timing_pkg::ZQ_STEP;
    end
  end

  // A row command that lands while the row counter still runs is too early.
  // A command exactly at the rounded count is honoured, since the counter is
  // in its last cycle then. The flag stays set until reset.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      timing_error_o <= 1'b0;
    else if (row_cmd && !row_free)
      timing_error_o <= 1'b1;
  end

  // Helper for checking: cycles since the last write and its expected delay.
  logic [7:0] since_wr;
  logic [7:0] exp_wst;
  logic [7:0] since_st;
  logic [7:0] exp_rec;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      since_wr <= 8'h00;
      exp_wst  <= 8'h00;
      since_st <= 8'h00;
      exp_rec  <= 8'h00;
    end
    else
    begin
      since_wr <= wr_cmd ? 8'h01 : ((since_wr == 8'hff) ? since_wr : since_wr + 8'h01);
      since_st <= wst_t.last ? 8'h01 : ((since_st == 8'hff) ? since_st : since_st + 8'h01);
      if (wr_cmd)
        exp_wst <= {4'h0, wl_i} + (bc4_fixed_i ? 8'h02 : 8'h04);
      if (wst_t.last)
        exp_rec <= {3'h0, wr_cycles_i} + 8'h01;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  wr_start_time_a: assert property (wr_start_o |-> since_wr == exp_wst + 8'h01)
    else $error("internal write start at wrong edge");
  wr_recovery_a: assert property (wr_prech_o |-> since_st == exp_rec)
    else $error("auto-precharge not after programmed recovery");
  pre_honour_a: assert property (
    (row_cmd && row_free && cmd_i == sdram_timing_pkg::CMD_PRE) |-> ##PRE_D row_free)
    else $error("precharge count longer than rounded value");
  early_flag_a: assert property ((row_cmd && !row_free) |=> timing_error_o)
    else $error("early row command not flagged");
  zq_window_a: assert property (zq_t.load |-> ##1 zq_t.busy [*8] ##[1:ZQ_D] zq_done_o)
    else $error("calibration not finished within window");
  pd_idle_a: assert property ((pwr == sdram_timing_pkg::PWR_DOWN) |-> !row_t.busy)
    else $error("power-down applied while row operation runs");
  pd_wait_a: assert property ((pwr == sdram_timing_pkg::PWR_PENDING && !cke_i && !any_busy)
    |=> power_down_o && pwr == sdram_timing_pkg::PWR_DOWN)
    else $error("power-down not applied once idle");
  pd_accept_a: assert property (
    (pwr == sdram_timing_pkg::PWR_ACTIVE && !cke_i) |=> pwr != sdram_timing_pkg::PWR_ACTIVE)
    else $error("clock-enable low not accepted");
endmodule : sdram_cycle_timing
`default_nettype wire

/* testbench/sdram_ctrl_model.sv */
// Controller model that spaces commands to the cycle timing block.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
  // Clock and reset.
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  // Requests from the bench.
  input  wire logic                   valid_i,
  input  wire sdram_timing_pkg::cmd_t op_i,
  input  wire logic                   rush_i,
  // Command pins and readiness.
  output var sdram_timing_pkg::cmd_t  cmd_o,
  output logic                        ready_o
);
  logic [7:0] gap;  // Edges left before the next command may go.

  // Spacing in whole edges, rounded up, so jitter never shortens it.
  function automatic logic [7:0] span(sdram_timing_pkg::cmd_t op);
    int ps;
    case (op)
      sdram_timing_pkg::CMD_ACT:  ps = sdram_timing_pkg::TRCD_PS;
      sdram_timing_pkg::CMD_PRE:  ps = sdram_timing_pkg::TRP_PS;
      sdram_timing_pkg::CMD_REF:  ps = sdram_timing_pkg::TRFC_PS;
      sdram_timing_pkg::CMD_ZQCS: ps = 64 * sdram_timing_pkg::TCK_PS;
      default:                    ps = sdram_timing_pkg::TCK_PS;
    endcase
    return 8'((ps - 1) / sdram_timing_pkg::TCK_PS + 1);
  endfunction : span

  // Ready only once the loaded count has run out.
  assign ready_o = (gap == 8'h00);

  // No register read burst is ever sent, so no mode register set follows one.
  // Termination is never driven, so no WL+AL-2 latency needs timing here.
  // One command per accepted request; rush is the deliberate misuse.
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      cmd_o <= sdram_timing_pkg::CMD_NOP;
      gap   <= 8'h00;
    end
    else if (valid_i && (ready_o || rush_i))
    begin
      cmd_o <= op_i;  // No read codes exist, so none is sent unlocked.
      gap   <= rush_i ? 8'h00 : span(op_i) - 8'h01;
    end
    else
    begin
      cmd_o <= sdram_timing_pkg::CMD_NOP;
      if (gap != 8'h00) gap <= gap - 8'h01;
    end
endmodule : sdram_ctrl_model
`default_nettype wire

/* testbench/tb_sdram_cycle_timing.sv */
// Self-checking bench for the SDRAM cycle timing block.
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_cycle_timing;
  logic clock_i = 1'b0;              // 50 MHz clock.
  logic rst_i = 1'b1;                // Reset, held at start.
  logic cke_i = 1'b1;                // Clock enable.
  logic bc4_fixed_i = 1'b0;          // Fixed chop mode.
  logic valid = 1'b0;                // Request to the model.
  logic rush = 1'b0;                 // Lets the model break spacing.
  logic [3:0] wl_i = 4'h5;           // Write latency.
  logic [4:0] wr_cycles_i = 5'h03;   // Write recovery.
  logic [5:0] zq_target_i = 6'h25;   // Impedance reference.
  logic [5:0] zq_code_o;
  sdram_timing_pkg::cmd_t op = sdram_timing_pkg::CMD_NOP;
  sdram_timing_pkg::cmd_t cmd_i;
  logic ready, row_busy_o, wr_start_o, wr_prech_o, power_down_o;
  logic zq_busy_o, zq_done_o, timing_error_o;
  int errors = 0;
  int n_tests = 0;
  int half = 10;                     // Half clock period in ns.

  sdram_cycle_timing i_dut (.clock_i, .rst_i, .cke_i, .cmd_i, .wl_i, .wr_cycles_i,
    .bc4_fixed_i, .zq_target_i, .row_busy_o, .wr_start_o, .wr_prech_o, .power_down_o,
    .zq_busy_o, .zq_done_o, .zq_code_o, .timing_error_o);
  sdram_ctrl_model i_ctrl (.clock_i, .rst_i, .valid_i(valid), .op_i(op), .rush_i(rush),
    .cmd_o(cmd_i), .ready_o(ready));

  // Free-running clock; one scenario stretches the half period.
  always #(half) clock_i = ~clock_i;

  // Selects one status output: 0 row, 1 start, 2 precharge, 3 zq done,
  // 5 zq busy, else power.
  function automatic logic pick(int sel);
    case (sel)
      0:       return row_busy_o;
      1:       return wr_start_o;
      2:       return wr_prech_o;
      3:       return zq_done_o;
      5:       return zq_busy_o;
      default: return power_down_o;
    endcase
  endfunction : pick

  // Compares one value and counts the outcome.
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask : chk

  // Holds a request until the model takes it; returns at that edge.
  task automatic issue(sdram_timing_pkg::cmd_t c);
    @(posedge clock_i);
    op    <= c;
    valid <= 1'b1;
    @(posedge clock_i);
    while (ready !== 1'b1 && !rush) @(posedge clock_i);
    valid <= 1'b0;
  endtask : issue

  // Edges until an output rises, then edges it stays high, both bounded.
  task automatic measure(int sel, output logic [7:0] lat, output logic [7:0] wid);
    lat = 8'h00;
    wid = 8'h00;
    while (pick(sel) !== 1'b1 && lat < 8'hc8)
    begin
      @(posedge clock_i);
      #1;
      lat++;
    end
    while (pick(sel) === 1'b1 && wid < 8'hc8)
    begin
      wid++;
      @(posedge clock_i);
      #1;
    end
  endtask : measure

  // Values seen right after reset.
  task automatic t_reset();
    chk("code at reset", 8'h20, 8'(zq_code_o));
    chk("power at reset", 8'h00, 8'(power_down_o));
  endtask : t_reset

  // Row timers: 13.125 ns and 160 ns at 20 ns round up to 1 and 8 edges.
  task automatic t_row();
    logic [7:0] lat, wid;
    issue(sdram_timing_pkg::CMD_PRE);
    measure(0, lat, wid);
    chk("row latency", 8'h02, lat);
    chk("precharge span", 8'h01, wid);
    issue(sdram_timing_pkg::CMD_PRE);
    issue(sdram_timing_pkg::CMD_ACT);
    repeat (4) @(posedge clock_i);
    issue(sdram_timing_pkg::CMD_REF);
    measure(0, lat, wid);
    chk("refresh span", 8'h08, wid);
    chk("legal spacing", 8'h00, 8'(timing_error_o));
  endtask : t_row

  // Write start in both chop modes, recovery taken from the set count.
  task automatic t_write();
    logic [7:0] lat, wid, gap3;
    for (int b = 0; b < 2; b++)
      for (int w = 3; w <= 6; w += 3)
      begin
        @(posedge clock_i);
        bc4_fixed_i <= b[0];
        wr_cycles_i <= 5'(w);
        issue(sdram_timing_pkg::CMD_WRA);
        measure(1, lat, wid);
        chk("write start", 8'(wl_i) + ((b == 1) ? 8'h03 : 8'h05), lat);
        chk("start width", 8'h01, wid);
        measure(2, lat, wid);
        if (w == 3) gap3 = lat;
        else chk("recovery step", gap3 + 8'h03, lat);
        repeat (12) @(posedge clock_i);
      end
  endtask : t_write

  // Short calibration finishes after 64 edges and steps the code.
  task automatic t_zq();
    logic [7:0] lat, wid;
    issue(sdram_timing_pkg::CMD_ZQCS);
    measure(3, lat, wid);
    chk("zq window", 8'h41, lat);
    chk("zq code", 8'h21, 8'(zq_code_o));
    issue(sdram_timing_pkg::CMD_ZQCS);
    measure(5, lat, wid);
    chk("zq busy span", 8'h40, wid);
    chk("zq second code", 8'h22, 8'(zq_code_o));
  endtask : t_zq

  // Idle entry, then entry with a refresh still running.
  task automatic t_power();
    logic [7:0] lat, wid;
    @(posedge clock_i);
    cke_i <= 1'b0;
    measure(4, lat, wid);
    chk("idle entry", 8'h01, lat);
    issue(sdram_timing_pkg::CMD_ACT);
    repeat (3) @(posedge clock_i);
    chk("ignored when down", 8'h00, 8'(row_busy_o));
    cke_i <= 1'b1;
    issue(sdram_timing_pkg::CMD_REF);
    @(posedge clock_i);
    cke_i <= 1'b0;  // One edge after refresh meets the entry minimum.
    measure(4, lat, wid);
    chk("pending entry", 8'h01, 8'(lat >= 8'h08 && lat < 8'h10));
    @(posedge clock_i);
    cke_i <= 1'b1;
  endtask : t_power

  // Slower clock, and an activate exactly at the refresh count: the device
  // counts edges, so the activate is taken and its own timer extends busy.
  task automatic t_slow();
    logic [7:0] lat, wid;
    @(posedge clock_i);
    half = 25;  // Longer period; only the refresh interval bounds it.
    issue(sdram_timing_pkg::CMD_REF);
    issue(sdram_timing_pkg::CMD_ACT);
    measure(0, lat, wid);
    chk("act at count", 8'h03, wid);
    chk("count honoured", 8'h00, 8'(timing_error_o));
    half = 10;
  endtask : t_slow

  // Spacing broken on purpose: the early row command is refused.
  task automatic t_err();
    @(posedge clock_i);
    rush <= 1'b1;
    issue(sdram_timing_pkg::CMD_REF);
    issue(sdram_timing_pkg::CMD_ACT);
    rush <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("spacing error", 8'h01, 8'(timing_error_o));
  endtask : t_err

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Main sequence after a twelve-cycle reset.
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_row();
    t_write();
    t_zq();
    t_power();
    t_slow();
    t_err();
    summarize();
  end

  // Watchdog at about six and a half times the expected run length.
  initial
  begin
    #100000;
    errors++;
    summarize();
  end
endmodule : tb_sdram_cycle_timing
`default_nettype wire
